// file: flash_block_select.sv
// Flash block select, RAM overlay and wait-state control register bank
// Assumes an APB master on i_core_clk and mode/supply pins from outside
`timescale 1ns/1ns
`include "flash_sel_regs.svh"
module flash_block_select
    import flash_sel_pkg::*;
(
    // Clock and reset
    input  wire logic        i_core_clk,
    input  wire logic        i_rst,
    // APB slave
    input  wire logic        i_psel,
    input  wire logic        i_penable,
    input  wire logic        i_pwrite,
    input  wire logic [11:0] i_paddr,
    input  wire logic [31:0] i_pwdata,
    input  wire logic [3:0]  i_pstrb,
    output logic      [31:0] o_prdata,
    output logic             o_pready,
    output logic             o_pslverr,
    // Pins and standby
    input  wire logic [1:0]  i_mode_pins,
    input  wire logic        i_supply_12v,
    input  wire logic        i_hw_standby,
    input  wire logic        i_sw_standby,
    input  wire logic        i_irq,
    // Flash mode requests
    input  wire logic        i_prog_req,
    input  wire logic        i_erase_req,
    input  wire logic        i_pverify_req,
    input  wire logic        i_everify_req,
    input  wire logic [15:0] i_flash_addr,
    output logic             o_prog_en,
    output logic             o_erase_en,
    output logic             o_pverify_en,
    output logic             o_everify_en,
    output logic             o_flash_protect,
    // CPU address overlay
    input  wire logic [15:0] i_cpu_addr,
    output logic             o_ram_redirect,
    output logic      [15:0] o_ram_addr,
    // Clock and wait-state control, block select bits
    output logic             o_periph_clk_div,
    output logic      [1:0]  o_wait_mode,
    output logic      [1:0]  o_wait_count,
    output flash_sel_pkg::sel_byte_t o_large_block_bits,
    output flash_sel_pkg::sel_byte_t o_small_block_bits
);
    import flash_sel_pkg::*;

    // Large select one-hot for an address
    function automatic sel_byte_t large_hit(input logic [15:0] a);
        sel_byte_t h;
        h = 8'h00;
        if (a >= 16'h1000 && a <= 16'h1FFF) h[0] = 1'b1;
        if (a >= 16'h2000 && a <= 16'h3FFF) h[1] = 1'b1;
        if (a >= 16'h4000 && a <= 16'h5FFF) h[2] = 1'b1;
        if (a >= 16'h6000 && a <= 16'h7FFF) h[3] = 1'b1;
        if (a >= 16'h8000 && a <= 16'h9FFF) h[4] = 1'b1;
        if (a >= 16'hA000 && a <= 16'hBFFF) h[5] = 1'b1;
        if (a >= 16'hC000 && a <= 16'hEF7F) h[6] = 1'b1;
        if (a >= 16'hEF80 && a <= 16'hF77F) h[7] = 1'b1;
        return h;
    endfunction

    // Small select one-hot for an address
    function automatic sel_byte_t small_hit(input logic [15:0] a);
        sel_byte_t h;
        h = 8'h00;
        if (a <= 16'h007F) h[0] = 1'b1;
        if (a >= 16'h0080 && a <= 16'h00FF) h[1] = 1'b1;
        if (a >= 16'h0100 && a <= 16'h017F) h[2] = 1'b1;
        if (a >= 16'h0180 && a <= 16'h01FF) h[3] = 1'b1;
        if (a >= 16'h0200 && a <= 16'h03FF) h[4] = 1'b1;
        if (a >= 16'h0400 && a <= 16'h07FF) h[5] = 1'b1;
        if (a >= 16'h0800 && a <= 16'h0BFF) h[6] = 1'b1;
        if (a >= 16'h0C00 && a <= 16'h0FFF) h[7] = 1'b1;
        return h;
    endfunction

    // Pin synchroniser: mode pins and supply detect
    logic [2:0] pin_s1_r;
    logic [2:0] pin_s2_r;
    logic [2:0] pin_s3_r;
    logic [2:0] pin_stable_r;
    logic [2:0] pin_stable_nxt;

    assign pin_stable_nxt = (pin_s2_r == pin_s3_r) ? pin_s2_r : pin_stable_r;

    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            pin_s1_r     <= 3'h0;
            pin_s2_r     <= 3'h0;
            pin_s3_r     <= 3'h0;
            pin_stable_r <= 3'h0;
        end else begin
            pin_s1_r     <= {i_supply_12v, i_mode_pins};
            pin_s2_r     <= pin_s1_r;
            pin_s3_r     <= pin_s2_r;
            pin_stable_r <= pin_stable_nxt;
        end
    end

    wire logic supply_ok = pin_stable_r[2];
    op_mode_t  op_mode;

    always_comb begin
        case (pin_stable_r[1:0])
            `PIN_MODE_1: op_mode = OP_MODE_1;
            `PIN_MODE_2: op_mode = OP_MODE_2;
            `PIN_MODE_3: op_mode = OP_MODE_3;
            default:     op_mode = OP_MODE_NONE;
        endcase
    end

    // APB decode
    wire logic setup_phase  = i_psel && !i_penable;
    wire logic access_phase = i_psel && i_penable;
    wire logic hit_large    = (i_paddr == `OFS_LARGE_SEL);
    wire logic hit_small    = (i_paddr == `OFS_SMALL_SEL);
    wire logic hit_wait     = (i_paddr == `OFS_WAIT_OVL);
    wire logic hit_status   = (i_paddr == `OFS_STATUS);
    wire logic hit_any      = hit_large || hit_small || hit_wait || hit_status;
    wire logic wr_lane0     = access_phase && i_pwrite && i_pstrb[0];

    wire logic flash_off    = (op_mode == OP_MODE_1);
    wire logic sel_access   = !flash_off && supply_ok;
    wire logic sel_clear    = i_rst || i_hw_standby || i_sw_standby || !supply_ok;

    // Block select registers
    sel_byte_t large_r;
    sel_byte_t large_nxt;
    sel_byte_t small_r;
    sel_byte_t small_nxt;
    sel_byte_t large_wmask;

    assign large_wmask = (op_mode == OP_MODE_2) ? 8'h7F : 8'hFF;
    assign large_nxt   = (wr_lane0 && hit_large && sel_access)
                       ? ((i_pwdata[7:0] & large_wmask) | (large_r & ~large_wmask))
                       : large_r;
    assign small_nxt   = (wr_lane0 && hit_small && sel_access)
                       ? i_pwdata[7:0] : small_r;

    always_ff @(posedge i_core_clk) begin
        if (sel_clear) begin
            large_r <= `RST_SEL;
            small_r <= `RST_SEL;
        end else begin
            large_r <= large_nxt;
            small_r <= small_nxt;
        end
    end

    // Wait-state and overlay control register
    sel_byte_t wait_r;
    sel_byte_t wait_nxt;

    assign wait_nxt = (wr_lane0 && hit_wait) ? i_pwdata[7:0] : wait_r;

    always_ff @(posedge i_core_clk) begin
        if (i_rst || i_hw_standby) begin
            wait_r <= `RST_WAIT_OVL;
        end else begin
            wait_r <= wait_nxt;
        end
    end

    // Overlay state
    wire logic [1:0] ovl_pat  = {wait_r[`BIT_OVL_HIGH], wait_r[`BIT_OVL_LOW]};
    wire logic ovl_single     = ovl_pat[1] ^ ovl_pat[0];
    wire logic ovl_both       = &ovl_pat;
    logic      ovl_armed_r;
    logic      ovl_armed_nxt;

    assign ovl_armed_nxt = ovl_both && (ovl_armed_r || (i_irq && supply_ok));

    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            ovl_armed_r <= 1'b0;
        end else begin
            ovl_armed_r <= ovl_armed_nxt;
        end
    end

    // Address overlay decode
    wire logic in_lo  = (i_cpu_addr <= `OVL_LO_END);
    wire logic in_a   = (i_cpu_addr >= `OVL_A_START) && (i_cpu_addr <= `OVL_A_END);
    wire logic in_b   = (i_cpu_addr >= `OVL_A_START) && (i_cpu_addr <= `OVL_B_END);
    logic      redirect;

    always_comb begin
        case (ovl_pat)
            2'b01:   redirect = in_a;
            2'b10:   redirect = in_b;
            2'b11:   redirect = in_lo && ovl_armed_r;
            default: redirect = 1'b0;
        endcase
    end

    logic        redirect_r;
    logic [15:0] ram_addr_r;

    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            redirect_r <= 1'b0;
            ram_addr_r <= 16'h0000;
        end else begin
            redirect_r <= redirect;
            ram_addr_r <= redirect ? (i_cpu_addr | `RAM_BASE) : 16'h0000;
        end
    end

    // Program and erase gating
    wire logic protect  = ovl_single;
    wire logic blk_hit  = |(large_hit(i_flash_addr) & large_r)
                       || |(small_hit(i_flash_addr) & small_r);
    wire logic pe_allow = blk_hit && !protect && sel_access;

    // APB read data
    sel_byte_t rd_byte;
    sel_byte_t sel_rd_large;
    sel_byte_t sel_rd_small;
    sel_byte_t status_byte;

    assign sel_rd_large = flash_off ? `READ_ALL_ONES
                        : (supply_ok ? large_r
                        : ((op_mode == OP_MODE_3) ? `READ_ALL_ONES : 8'h00));
    assign sel_rd_small = flash_off ? `READ_ALL_ONES
                        : (supply_ok ? small_r
                        : ((op_mode == OP_MODE_3) ? `READ_ALL_ONES : 8'h00));
    assign status_byte  = {3'b000, ovl_armed_r, protect, supply_ok, pin_stable_r[1:0]};

    always_comb begin
        rd_byte = 8'h00;
        if (hit_large)  rd_byte = sel_rd_large;
        if (hit_small)  rd_byte = sel_rd_small;
        if (hit_wait)   rd_byte = wait_r;
        if (hit_status) rd_byte = status_byte;
    end

    logic [31:0] prdata_r;
    logic        slverr_r;

    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            prdata_r <= 32'h0000_0000;
            slverr_r <= 1'b0;
        end else if (setup_phase) begin
            prdata_r <= {24'h00_0000, rd_byte};
            slverr_r <= !hit_any;
        end
    end

    assign o_prdata  = prdata_r;
    assign o_pready  = 1'b1;
    assign o_pslverr = access_phase && slverr_r;

    // Outputs
    assign o_prog_en          = i_prog_req && pe_allow;
    assign o_erase_en         = i_erase_req && pe_allow;
    assign o_pverify_en       = i_pverify_req && sel_access;
    assign o_everify_en       = i_everify_req && sel_access;
    assign o_flash_protect    = protect;
    assign o_ram_redirect     = redirect_r;
    assign o_ram_addr         = ram_addr_r;
    assign o_periph_clk_div   = wait_r[`BIT_CLK_DIV];
    assign o_wait_mode        = wait_r[3:2];
    assign o_wait_count       = wait_r[1:0];
    assign o_large_block_bits = large_r;
    assign o_small_block_bits = small_r;

    // Checks
    AST_SEL_CLEAR: assert property (@(posedge i_core_clk)
        (i_sw_standby || i_hw_standby) |=> (large_r == 8'h00 && small_r == 8'h00))
        else $error("select not cleared by standby");

    AST_SUPPLY_CLEAR: assert property (@(posedge i_core_clk) disable iff (i_rst)
        !supply_ok |=> (small_r == 8'h00))
        else $error("small select kept without supply");

    AST_MODE1_READ: assert property (@(posedge i_core_clk) disable iff (i_rst)
        (setup_phase && hit_large && flash_off) |=> (o_prdata[7:0] == 8'hFF))
        else $error("mode 1 select read not FF");

    AST_MODE2_TOP: assert property (@(posedge i_core_clk)
        disable iff (i_rst || i_hw_standby || i_sw_standby || !supply_ok)
        (op_mode == OP_MODE_2 && $stable(op_mode)) |=> $stable(large_r[7]))
        else $error("top large bit changed in mode 2");

    AST_WAIT_RESET: assert property (@(posedge i_core_clk)
        i_hw_standby |=> (o_wait_mode == 2'b10 && o_wait_count == 2'b00 && !o_periph_clk_div))
        else $error("wait register not reset by standby");

    AST_WAIT_KEEP: assert property (@(posedge i_core_clk)
        disable iff (i_rst || i_hw_standby)
        (i_sw_standby && !(access_phase && i_pwrite)) |=> $stable(wait_r))
        else $error("wait register lost in software standby");

    AST_PROTECT: assert property (@(posedge i_core_clk) disable iff (i_rst)
        (ovl_pat == 2'b01 || ovl_pat == 2'b10) |-> (!o_prog_en && !o_erase_en))
        else $error("program allowed under overlay protect");

    AST_ARM: assert property (@(posedge i_core_clk) disable iff (i_rst)
        (ovl_both && !ovl_armed_r && !(i_irq && supply_ok)) |=> !ovl_armed_r)
        else $error("overlay armed without interrupt");

    AST_REDIRECT: assert property (@(posedge i_core_clk) disable iff (i_rst)
        (ovl_pat == 2'b10 && i_cpu_addr == 16'h0100) |=>
        (o_ram_redirect && o_ram_addr == 16'hF900))
        else $error("overlay pattern 10 decode wrong");

    AST_UNSELECTED: assert property (@(posedge i_core_clk) disable iff (i_rst)
        (large_r == 8'h00 && small_r == 8'h00) |-> (!o_prog_en && !o_erase_en))
        else $error("program allowed with no block selected");

    AST_LARGE_SUPPLY_CLEAR: assert property (@(posedge i_core_clk) disable iff (i_rst)
        !supply_ok |=> (large_r == 8'h00))
        else $error("large select kept without supply");

    AST_SMALL_MODE1_READ: assert property (@(posedge i_core_clk) disable iff (i_rst)
        (setup_phase && hit_small && flash_off) |=> (o_prdata[7:0] == 8'hFF))
        else $error("mode 1 small select read not FF");

    AST_MODE1_IGNORE: assert property (@(posedge i_core_clk) disable iff (i_rst)
        (flash_off && !sel_clear)
        |=> ($stable(large_r) && $stable(small_r)))
        else $error("select written in mode 1");

    AST_MODE3_READ: assert property (@(posedge i_core_clk) disable iff (i_rst)
        (setup_phase && (hit_large || hit_small) && op_mode == OP_MODE_3 && !supply_ok)
        |=> (o_prdata[7:0] == 8'hFF))
        else $error("mode 3 select read not FF without supply");

    AST_SINGLE_REDIRECT: assert property (@(posedge i_core_clk) disable iff (i_rst)
        (ovl_pat == 2'b01 && i_cpu_addr == 16'h0080) |=>
        (o_ram_redirect && o_ram_addr == 16'hF880))
        else $error("overlay pattern 01 decode wrong");

    AST_BOTH_REDIRECT: assert property (@(posedge i_core_clk) disable iff (i_rst)
        (ovl_both && ovl_armed_r && i_cpu_addr == 16'h0000) |=>
        (o_ram_redirect && o_ram_addr == 16'hF800))
        else $error("armed overlay pattern 11 decode wrong");

    AST_UNARMED_FLASH: assert property (@(posedge i_core_clk) disable iff (i_rst)
        (ovl_both && !ovl_armed_r) |=> !o_ram_redirect)
        else $error("overlay redirected before interrupt");

    AST_WAIT_WRITE: assert property (@(posedge i_core_clk)
        disable iff (i_rst || i_hw_standby)
        (wr_lane0 && hit_wait) |=> (wait_r == $past(i_pwdata[7:0])))
        else $error("wait register write not stored");

    AST_VERIFY_OPEN: assert property (@(posedge i_core_clk) disable iff (i_rst)
        (ovl_single && sel_access && i_pverify_req) |-> o_pverify_en)
        else $error("verify refused under overlay protect");
endmodule

// file: flash_sel_regs.svh
// Register offsets, field positions, reset values and address ranges
// Assumes inclusion by the package, the register bank and the bench
`ifndef FLASH_SEL_REGS_SVH
`define FLASH_SEL_REGS_SVH

`define OFS_LARGE_SEL      12'h000
`define OFS_SMALL_SEL      12'h004
`define OFS_WAIT_OVL       12'h008
`define OFS_STATUS         12'h00C

`define RST_SEL            8'h00
`define RST_WAIT_OVL       8'h08
`define READ_ALL_ONES      8'hFF

`define BIT_OVL_HIGH       7
`define BIT_OVL_LOW        6
`define BIT_CLK_DIV        5
`define BIT_RSVD           4
`define BIT_LARGE_TOP      7

`define PIN_MODE_1         2'b01
`define PIN_MODE_2         2'b10
`define PIN_MODE_3         2'b11

`define RAM_BASE           16'hF800
`define OVL_LO_START       16'h0000
`define OVL_LO_END         16'h007F
`define OVL_A_START        16'h0080
`define OVL_A_END          16'h00FF
`define OVL_B_END          16'h017F

`endif

// file: flash_sel_pkg.sv
// Types shared by the flash block select register bank
// Assumes the constants header is on the include path
package flash_sel_pkg;
    `include "flash_sel_regs.svh"

    typedef enum logic [1:0] {
        OP_MODE_1,
        OP_MODE_2,
        OP_MODE_3,
        OP_MODE_NONE
    } op_mode_t;

    typedef logic [7:0] sel_byte_t;
endpackage

// file: tb.sv
// Self-checking bench for the flash block select register bank
// Assumes the design package and constants header are compiled before it
`timescale 1ns/1ns
`include "flash_sel_regs.svh"
module tb;
    import flash_sel_pkg::*;
    typedef struct packed {
        logic [1:0]  mode;
        logic        sup;
        logic [11:0] addr;
        logic [7:0]  wd;
        logic [7:0]  exp;
        logic        err;
    } row_t;
    logic        i_core_clk    = 1'b0;
    logic        i_rst         = 1'b1;
    logic        i_psel        = 1'b0;
    logic        i_penable     = 1'b0;
    logic        i_pwrite      = 1'b0;
    logic [11:0] i_paddr       = 12'h000;
    logic [31:0] i_pwdata      = 32'h0000_0000;
    logic [3:0]  i_pstrb       = 4'hF;
    logic [1:0]  i_mode_pins   = 2'b11;
    logic        i_supply_12v  = 1'b1;
    logic        i_hw_standby  = 1'b0;
    logic        i_sw_standby  = 1'b0;
    logic        i_irq         = 1'b0;
    logic        i_prog_req    = 1'b0;
    logic        i_erase_req   = 1'b0;
    logic        i_pverify_req = 1'b0;
    logic        i_everify_req = 1'b0;
    logic [15:0] i_flash_addr  = 16'h0000;
    logic [15:0] i_cpu_addr    = 16'h0000;
    logic [31:0] o_prdata;
    logic        o_pready;
    logic        o_pslverr;
    logic        o_prog_en;
    logic        o_erase_en;
    logic        o_pverify_en;
    logic        o_everify_en;
    logic        o_flash_protect;
    logic        o_ram_redirect;
    logic [15:0] o_ram_addr;
    logic        o_periph_clk_div;
    logic [1:0]  o_wait_mode;
    logic [1:0]  o_wait_count;
    sel_byte_t   o_large_block_bits;
    sel_byte_t   o_small_block_bits;
    int          fails         = 0;
    int          tests_run     = 0;
    int          cycles        = 0;
    logic [31:0] d;
    logic        e;
    row_t        rows [9] = '{
        '{2'b11, 1'b1, `OFS_LARGE_SEL, 8'hA5, 8'hA5, 1'b0},
        '{2'b11, 1'b1, `OFS_SMALL_SEL, 8'h3C, 8'h3C, 1'b0},
        '{2'b01, 1'b1, `OFS_LARGE_SEL, 8'h12, 8'hFF, 1'b0},
        '{2'b01, 1'b1, `OFS_SMALL_SEL, 8'h12, 8'hFF, 1'b0},
        '{2'b10, 1'b1, `OFS_LARGE_SEL, 8'hFF, 8'h7F, 1'b0},
        '{2'b11, 1'b0, `OFS_LARGE_SEL, 8'h55, 8'hFF, 1'b0},
        '{2'b10, 1'b0, `OFS_SMALL_SEL, 8'h55, 8'h00, 1'b0},
        '{2'b11, 1'b1, `OFS_WAIT_OVL,  8'h3F, 8'h3F, 1'b0},
        '{2'b11, 1'b1, 12'h010,        8'h77, 8'h00, 1'b1}
    };

    always #4 i_core_clk = ~i_core_clk;

    flash_block_select DUT (
        .i_core_clk(i_core_clk), .i_rst(i_rst), .i_psel(i_psel), .i_penable(i_penable),
        .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata), .i_pstrb(i_pstrb),
        .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr),
        .i_mode_pins(i_mode_pins), .i_supply_12v(i_supply_12v),
        .i_hw_standby(i_hw_standby), .i_sw_standby(i_sw_standby), .i_irq(i_irq),
        .i_prog_req(i_prog_req), .i_erase_req(i_erase_req),
        .i_pverify_req(i_pverify_req), .i_everify_req(i_everify_req),
        .i_flash_addr(i_flash_addr), .o_prog_en(o_prog_en), .o_erase_en(o_erase_en),
        .o_pverify_en(o_pverify_en), .o_everify_en(o_everify_en),
        .o_flash_protect(o_flash_protect), .i_cpu_addr(i_cpu_addr),
        .o_ram_redirect(o_ram_redirect), .o_ram_addr(o_ram_addr),
        .o_periph_clk_div(o_periph_clk_div), .o_wait_mode(o_wait_mode),
        .o_wait_count(o_wait_count), .o_large_block_bits(o_large_block_bits),
        .o_small_block_bits(o_small_block_bits)
    );

    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            fails++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge i_core_clk);
    endtask

    // One APB transfer; answer taken at the edge where pready is seen high
    task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] wd,
                       output logic [31:0] rdat, output logic er);
        @(posedge i_core_clk);
        i_psel   <= 1'b1;
        i_pwrite <= w;
        i_paddr  <= a;
        i_pwdata <= {24'h00_0000, wd};
        @(posedge i_core_clk);
        i_penable <= 1'b1;
        do @(posedge i_core_clk); while (o_pready !== 1'b1);
        rdat = o_prdata;
        er = o_pslverr;
        i_psel    <= 1'b0;
        i_penable <= 1'b0;
    endtask

    task automatic wr(input logic [11:0] a, input logic [7:0] wd);
        logic [31:0] x;
        logic        y;
        apb(1'b1, a, wd, x, y);
    endtask

    always @(posedge i_core_clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            fails = fails + 1;
            finish_test();
        end
    end

    initial begin
        cyc(20);
        i_rst <= 1'b0;
        cyc(6);
        apb(1'b0, `OFS_LARGE_SEL, 8'h00, d, e);
        chk(d, 32'h0000_0000);
        apb(1'b0, `OFS_SMALL_SEL, 8'h00, d, e);
        chk(d, 32'h0000_0000);
        apb(1'b0, `OFS_WAIT_OVL, 8'h00, d, e);
        chk(d, 32'h0000_0008);
        chk({o_pready, o_wait_mode}, 3'b110);
        i_pstrb <= 4'hE;
        wr(`OFS_WAIT_OVL, 8'h12);
        i_pstrb <= 4'hF;
        apb(1'b0, `OFS_WAIT_OVL, 8'h00, d, e);
        chk(d, 32'h0000_0008);
        $display("test reset done");
        foreach (rows[k]) begin
            i_supply_12v <= 1'b0;
            cyc(6);
            i_mode_pins  <= rows[k].mode;
            i_supply_12v <= rows[k].sup;
            cyc(6);
            wr(rows[k].addr, rows[k].wd);
            apb(1'b0, rows[k].addr, 8'h00, d, e);
            chk(d, {24'h00_0000, rows[k].exp});
            chk(e, rows[k].err);
        end
        $display("test register table done");
        i_mode_pins  <= 2'b11;
        i_supply_12v <= 1'b1;
        cyc(6);
        wr(`OFS_LARGE_SEL, 8'hFF);
        wr(`OFS_SMALL_SEL, 8'hFF);
        wr(`OFS_WAIT_OVL, 8'h35);
        cyc(1);
        chk(o_periph_clk_div, 1'b1);
        chk({o_wait_mode, o_wait_count}, 4'h5);
        chk({o_large_block_bits, o_small_block_bits}, 16'hFFFF);
        i_sw_standby <= 1'b1;
        cyc(2);
        i_sw_standby <= 1'b0;
        apb(1'b0, `OFS_LARGE_SEL, 8'h00, d, e);
        chk(d, 32'h0000_0000);
        apb(1'b0, `OFS_SMALL_SEL, 8'h00, d, e);
        chk(d, 32'h0000_0000);
        apb(1'b0, `OFS_WAIT_OVL, 8'h00, d, e);
        chk(d, 32'h0000_0035);
        i_hw_standby <= 1'b1;
        cyc(2);
        i_hw_standby <= 1'b0;
        apb(1'b0, `OFS_WAIT_OVL, 8'h00, d, e);
        chk(d, 32'h0000_0008);
        $display("test standby done");
        wr(`OFS_LARGE_SEL, 8'h01);
        wr(`OFS_SMALL_SEL, 8'h80);
        i_prog_req   <= 1'b1;
        i_flash_addr <= 16'h1000;
        cyc(1);
        chk(o_prog_en, 1'b1);
        i_flash_addr <= 16'h2000;
        cyc(1);
        chk(o_prog_en, 1'b0);
        i_prog_req    <= 1'b0;
        i_erase_req   <= 1'b1;
        i_everify_req <= 1'b1;
        i_flash_addr  <= 16'h0C00;
        cyc(1);
        chk(o_erase_en, 1'b1);
        chk(o_everify_en, 1'b1);
        i_erase_req   <= 1'b0;
        i_everify_req <= 1'b0;
        i_prog_req    <= 1'b1;
        i_pverify_req <= 1'b1;
        i_flash_addr  <= 16'h1000;
        i_cpu_addr    <= 16'h0080;
        wr(`OFS_WAIT_OVL, 8'h40);
        cyc(2);
        chk(o_flash_protect, 1'b1);
        chk(o_prog_en, 1'b0);
        chk(o_pverify_en, 1'b1);
        chk({o_ram_redirect, o_ram_addr}, 17'h1_F880);
        i_cpu_addr <= 16'h0100;
        cyc(2);
        chk(o_ram_redirect, 1'b0);
        wr(`OFS_WAIT_OVL, 8'h80);
        cyc(2);
        chk({o_ram_redirect, o_ram_addr}, 17'h1_F900);
        i_cpu_addr <= 16'h0000;
        wr(`OFS_WAIT_OVL, 8'hC0);
        cyc(2);
        chk(o_flash_protect, 1'b0);
        chk(o_ram_redirect, 1'b0);
        i_irq <= 1'b1;
        cyc(1);
        i_irq <= 1'b0;
        cyc(2);
        chk({o_ram_redirect, o_ram_addr}, 17'h1_F800);
        apb(1'b0, `OFS_STATUS, 8'h00, d, e);
        chk(d, 32'h0000_0017);
        wr(`OFS_WAIT_OVL, 8'h00);
        cyc(2);
        chk(o_ram_redirect, 1'b0);
        chk(o_prog_en, 1'b1);
        $display("test overlay done");
        finish_test();
    end
endmodule
